/* File: rtl/apfc_pkg.sv */
// Shared constants and carrier types for the PLL feedback configuration bank
package apfc_pkg;

   localparam int FRAC_W = 27;
   localparam int INT_W  = 10;
   localparam int FRAC_BYTES = 4;
   localparam int INT_BYTES  = 2;

   // Base of the bank in the 32-bit configuration address space
   localparam logic [31:0] APLL_BASE = 32'h0000_0100;

   localparam logic [7:0] OFS_FRAC0 = 8'h00;
   localparam logic [7:0] OFS_FRAC3 = 8'h03;
   localparam logic [7:0] OFS_INT0  = 8'h04;
   localparam logic [7:0] OFS_INT1  = 8'h05;
   localparam logic [7:0] OFS_SDM   = 8'h06;
   localparam logic [7:0] OFS_CFG   = 8'h07;
   localparam logic [7:0] OFS_LPF   = 8'h08;

   localparam logic [FRAC_W-1:0] FRAC_RST = 27'h0000000;
   localparam logic [INT_W-1:0]  INT_RST  = 10'h06C;
   localparam logic [7:0] SDM_RST = 8'h03;
   localparam logic [7:0] CFG_RST = 8'h01;
   localparam logic [7:0] LPF_RST = 8'h76;

   localparam logic [7:0] SDM_MASK = 8'h3F;
   localparam logic [7:0] CFG_MASK = 8'h03;
   localparam logic [7:0] LPF_MASK = 8'hFF;

   localparam int SDM_DITHER_BIT = 5;
   localparam int SDM_SHAPE_BIT  = 4;
   localparam int SDM_GAIN_LSB   = 2;
   localparam int SDM_ORDER_LSB  = 0;
   localparam int CFG_REFSEL_BIT  = 1;
   localparam int CFG_DOUBLER_BIT = 0;
   localparam int LPF_BYPASS_BIT = 7;
   localparam int LPF_CAP_LSB    = 4;
   localparam int LPF_RES_LSB    = 0;

   typedef enum logic [1:0] {
      APFC_ORD_INTEGER,
      APFC_ORD_FIRST,
      APFC_ORD_SECOND,
      APFC_ORD_THIRD
   } apfc_order_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } apfc_acc_t;

   typedef struct packed {
      logic [FRAC_W-1:0] feedback_fraction_value;
      logic [INT_W-1:0]  feedback_integer_value;
      logic              dither_on;
      logic              dither_shaping_on;
      logic [1:0]        dither_gain_code;
      apfc_order_t       modulator_order_code;
      logic              ref_from_external_clock;
      logic              doubler_on;
      logic              vco_filter_bypass;
      logic [2:0]        pole_capacitor_code;
      logic [3:0]        filter_resistor_code;
   } apfc_pll_cfg_t;

endpackage : apfc_pkg

/* File: rtl/apfc_addr_form.sv */
// Forms the full configuration address and decodes a hit on the bank
`timescale 1ns/100ps
`default_nettype none
module apfc_addr_form
(
   input  wire logic [31:0] page_addr,
   input  wire logic [15:0] addr_lo,
   input  wire logic        addr_two_byte,
   output logic             hit,
   output logic [7:0]       offset
);

   logic [31:0] full_addr;

   always_comb
   begin
      // Page supplies every bit that the serial address does not carry
      if (addr_two_byte)
         full_addr = {page_addr[31:16], addr_lo};             // RULE_16
      else
         full_addr = {page_addr[31:8], addr_lo[7:0]};         // RULE_16
      hit    = (full_addr[31:8] == apfc_pkg::APLL_BASE[31:8]);
      offset = full_addr[7:0];
   end

endmodule : apfc_addr_form
`default_nettype wire

/* File: rtl/apfc_atomic_reg.sv */
// Byte-written register with staging copy, committed on a top-byte write
`timescale 1ns/100ps
`default_nettype none
module apfc_atomic_reg
#(
   parameter int          NBYTES = 4,
   parameter int          W      = 27,
   parameter logic [W-1:0] RST   = '0
)
(
   input  wire logic                  mclk,
   input  wire logic                  rstn,
   input  wire logic                  wr,
   input  wire logic [1:0]            byte_sel,
   input  wire logic [7:0]            wdata,
   output logic [8*NBYTES-1:0]        view,
   output logic [W-1:0]               live
);

   logic [W-1:0] stage_q;
   logic [8*NBYTES-1:0] stage_wide;
   logic [8*NBYTES-1:0] stage_d;

   always_comb
   begin
      stage_wide = (8*NBYTES)'(stage_q);
      stage_d    = stage_wide;
      stage_d[byte_sel*8 +: 8] = wdata;
      view = stage_wide;
   end

   // Lower bytes wait here; bits above W are dropped so they read as zero
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         stage_q <= RST;
      else if (wr)
         stage_q <= stage_d[W-1:0];                           // RULE_15 RULE_14
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         live <= RST;
      else if (wr && (byte_sel == 2'(NBYTES-1)))
         live <= stage_d[W-1:0];                              // RULE_02 RULE_04
   end

endmodule : apfc_atomic_reg
`default_nettype wire

/* File: rtl/apfc_feedback_regs.sv */
// PLL feedback divider, modulator, reference and loop-filter register bank
`timescale 1ns/100ps
`default_nettype none
// Operation
// [RULE_01] Hold 27-bit fraction numerator over a fixed two-to-the-27 denominator.
// [RULE_02] Fraction reaches the PLL only when its top byte is written.
// [RULE_03] Integer divider is 10 bits, read-write, resets to 6C hex.
// [RULE_04] Integer value reaches the PLL only when its upper byte is written.
// [RULE_05] Dither enable bit, one enables, resets to zero.
// [RULE_06] Dither shaping bit, one shapes dither, resets to zero.
// [RULE_07] Two-bit dither gain gives one, two, four or eight LSB steps.
// [RULE_08] Two-bit order: integer, first, second, third; resets to third.
// [RULE_09] Reference select: zero crystal input, one external clock; resets zero.
// [RULE_10] Doubler enable bit, one turns doubler on, resets to one.
// [RULE_11] Filter bypass bit: zero keeps current-source filter, one bypasses.
// [RULE_12] Three-bit pole capacitor code, ascending, resets to highest code.
// [RULE_13] Four-bit resistor code, ascending from zero ohm, resets to six.
// [RULE_14] Reserved bits read zero and ignore writes.
// [RULE_15] Lower divider bytes stay staged until the top-byte write commits.
// [RULE_16] One- or two-byte serial address, page register supplies upper bits.
module apfc_feedback_regs
(
   input  wire logic                   mclk,
   input  wire logic                   rstn,
   input  wire apfc_pkg::apfc_acc_t    acc,
   input  wire logic                   addr_two_byte,
   input  wire logic [31:0]            page_addr,
   output logic [7:0]                  rd_data,
   output logic                        rd_valid,
   output apfc_pkg::apfc_pll_cfg_t     pll_cfg
);

   logic        hit;
   logic [7:0]  offset;
   logic        wr_hit;
   logic        frac_wr;
   logic        int_wr;
   logic [1:0]  frac_sel;
   logic [1:0]  int_sel;
   logic [31:0] frac_view;
   logic [15:0] int_view;
   logic [apfc_pkg::FRAC_W-1:0] frac_live;
   logic [apfc_pkg::INT_W-1:0]  int_live;
   logic [7:0]  sdm_q;
   logic [7:0]  cfg_q;
   logic [7:0]  lpf_q;
   logic [7:0]  rd_mux;
   logic [7:0]  rd_data_q;
   logic        rd_valid_q;
   logic [7:0]  rd_off_q;

   apfc_addr_form u_addr
   (
      .page_addr     (page_addr),
      .addr_lo       (acc.addr),
      .addr_two_byte (addr_two_byte),
      .hit           (hit),
      .offset        (offset)
   );

   // Wrapping subtraction keeps the range test unsigned, with no always-true compare at offset zero
   function automatic logic in_span
   (
      input logic [7:0] ofs,
      input logic [7:0] first,
      input int         nbytes
   );
      return 8'(ofs - first) < 8'(nbytes);
   endfunction : in_span

   assign wr_hit  = acc.valid && acc.write && hit;
   assign frac_wr = wr_hit && in_span(offset, apfc_pkg::OFS_FRAC0, apfc_pkg::FRAC_BYTES);
   assign int_wr  = wr_hit && in_span(offset, apfc_pkg::OFS_INT0, apfc_pkg::INT_BYTES);
   assign frac_sel = 2'(offset - apfc_pkg::OFS_FRAC0);
   assign int_sel  = 2'(offset - apfc_pkg::OFS_INT0);

   // Numerator over a fixed 2^27 denominator, committed as one word
   apfc_atomic_reg
   #(
      .NBYTES (apfc_pkg::FRAC_BYTES),
      .W      (apfc_pkg::FRAC_W),
      .RST    (apfc_pkg::FRAC_RST)
   )
   u_frac
   (
      .mclk     (mclk),
      .rstn     (rstn),
      .wr       (frac_wr),                                    // RULE_01
      .byte_sel (frac_sel),
      .wdata    (acc.wdata),
      .view     (frac_view),
      .live     (frac_live)
   );

   apfc_atomic_reg
   #(
      .NBYTES (apfc_pkg::INT_BYTES),
      .W      (apfc_pkg::INT_W),
      .RST    (apfc_pkg::INT_RST)
   )
   u_int
   (
      .mclk     (mclk),
      .rstn     (rstn),
      .wr       (int_wr),                                     // RULE_03
      .byte_sel (int_sel),
      .wdata    (acc.wdata),
      .view     (int_view),
      .live     (int_live)
   );

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         sdm_q <= apfc_pkg::SDM_RST;                          // RULE_08
      else if (wr_hit && (offset == apfc_pkg::OFS_SDM))
         sdm_q <= acc.wdata & apfc_pkg::SDM_MASK;             // RULE_05 RULE_06 RULE_07 RULE_14
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         cfg_q <= apfc_pkg::CFG_RST;                          // RULE_10
      else if (wr_hit && (offset == apfc_pkg::OFS_CFG))
         cfg_q <= acc.wdata & apfc_pkg::CFG_MASK;             // RULE_09 RULE_14
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         lpf_q <= apfc_pkg::LPF_RST;                          // RULE_12 RULE_13
      else if (wr_hit && (offset == apfc_pkg::OFS_LPF))
         lpf_q <= acc.wdata & apfc_pkg::LPF_MASK;             // RULE_11
   end

   // Reads show the staged divider bytes, so software sees what it wrote
   always_comb
   begin
      rd_mux = 8'h00;
      if (hit)
      begin
         unique case (offset)
            8'h00:   rd_mux = frac_view[7:0];
            8'h01:   rd_mux = frac_view[15:8];
            8'h02:   rd_mux = frac_view[23:16];
            8'h03:   rd_mux = frac_view[31:24];
            8'h04:   rd_mux = int_view[7:0];
            8'h05:   rd_mux = int_view[15:8];
            8'h06:   rd_mux = sdm_q;
            8'h07:   rd_mux = cfg_q;
            8'h08:   rd_mux = lpf_q;
            default: rd_mux = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         rd_data_q  <= 8'h00;
         rd_valid_q <= 1'b0;
         rd_off_q   <= 8'h00;
      end
      else
      begin
         rd_data_q  <= (acc.valid && !acc.write) ? rd_mux : 8'h00;
         rd_valid_q <= acc.valid && !acc.write;
         rd_off_q   <= offset;
      end
   end

   assign rd_data  = rd_data_q;
   assign rd_valid = rd_valid_q;

   always_comb
   begin
      pll_cfg.feedback_fraction_value = frac_live;            // RULE_01
      pll_cfg.feedback_integer_value  = int_live;             // RULE_03
      pll_cfg.dither_on         = sdm_q[apfc_pkg::SDM_DITHER_BIT];            // RULE_05
      pll_cfg.dither_shaping_on = sdm_q[apfc_pkg::SDM_SHAPE_BIT];             // RULE_06
      pll_cfg.dither_gain_code  = sdm_q[apfc_pkg::SDM_GAIN_LSB +: 2];         // RULE_07
      pll_cfg.modulator_order_code =
         apfc_pkg::apfc_order_t'(sdm_q[apfc_pkg::SDM_ORDER_LSB +: 2]);      // RULE_08
      pll_cfg.ref_from_external_clock = cfg_q[apfc_pkg::CFG_REFSEL_BIT];     // RULE_09
      pll_cfg.doubler_on        = cfg_q[apfc_pkg::CFG_DOUBLER_BIT];           // RULE_10
      pll_cfg.vco_filter_bypass = lpf_q[apfc_pkg::LPF_BYPASS_BIT];            // RULE_11
      pll_cfg.pole_capacitor_code  = lpf_q[apfc_pkg::LPF_CAP_LSB +: 3];      // RULE_12
      pll_cfg.filter_resistor_code = lpf_q[apfc_pkg::LPF_RES_LSB +: 4];      // RULE_13
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   a_frac_commit: assert property // RULE_02
      (frac_wr && (frac_sel == 2'd3) |=>
       pll_cfg.feedback_fraction_value == $past({acc.wdata[2:0], frac_view[23:0]}))
      else $error("fraction not committed on top byte");

   a_frac_staged: assert property // RULE_15
      (!(frac_wr && (frac_sel == 2'd3)) |=> $stable(pll_cfg.feedback_fraction_value))
      else $error("fraction changed without top byte write");

   a_int_commit: assert property // RULE_04
      (int_wr && int_sel[0] |=>
       pll_cfg.feedback_integer_value == $past({acc.wdata[1:0], int_view[7:0]}))
      else $error("integer not committed on upper byte");

   a_int_staged: assert property // RULE_15
      (int_wr && !int_sel[0] |=> $stable(pll_cfg.feedback_integer_value))
      else $error("integer changed on lower byte write");

   a_reset_values: assert property // RULE_03
      ($past(!rstn) |-> pll_cfg.feedback_integer_value == apfc_pkg::INT_RST
       && pll_cfg.modulator_order_code == apfc_pkg::APFC_ORD_THIRD
       && pll_cfg.doubler_on && !pll_cfg.ref_from_external_clock
       && lpf_q == apfc_pkg::LPF_RST && pll_cfg.feedback_fraction_value == '0)
      else $error("wrong value after reset");

   a_dither_write: assert property // RULE_05
      (wr_hit && (offset == apfc_pkg::OFS_SDM) |=>
       pll_cfg.dither_on == $past(acc.wdata[5]) && pll_cfg.dither_shaping_on == $past(acc.wdata[4]))
      else $error("dither controls not taken");

   a_gain_order: assert property // RULE_07
      (wr_hit && (offset == apfc_pkg::OFS_SDM) |=>
       pll_cfg.dither_gain_code == $past(acc.wdata[3:2])
       && pll_cfg.modulator_order_code == apfc_pkg::apfc_order_t'($past(acc.wdata[1:0])))
      else $error("gain or order not taken");

   a_ref_write: assert property // RULE_09
      (wr_hit && (offset == apfc_pkg::OFS_CFG) |=>
       pll_cfg.ref_from_external_clock == $past(acc.wdata[1]) && pll_cfg.doubler_on == $past(acc.wdata[0]))
      else $error("reference config not taken");

   a_lpf_write: assert property // RULE_12
      (wr_hit && (offset == apfc_pkg::OFS_LPF) |=>
       {pll_cfg.vco_filter_bypass, pll_cfg.pole_capacitor_code, pll_cfg.filter_resistor_code}
       == $past(acc.wdata))
      else $error("loop filter config not taken");

   a_rsvd_zero: assert property // RULE_14
      (rd_valid && (rd_off_q == apfc_pkg::OFS_SDM) |-> rd_data[7:6] == 2'b00)
      else $error("reserved modulator bits read nonzero");

   a_rsvd_frac: assert property // RULE_14
      (rd_valid && (rd_off_q == apfc_pkg::OFS_FRAC3) |-> rd_data[7:3] == 5'h00)
      else $error("reserved fraction bits read nonzero");

   a_rsvd_int: assert property // RULE_14
      (rd_valid && (rd_off_q == apfc_pkg::OFS_INT1) |-> rd_data[7:2] == 6'h00)
      else $error("reserved integer bits read nonzero");

   a_rsvd_cfg: assert property // RULE_14
      (rd_valid && (rd_off_q == apfc_pkg::OFS_CFG) |-> rd_data[7:2] == 6'h00)
      else $error("reserved reference bits read nonzero");

   a_int_hold: assert property // RULE_04
      (!(int_wr && int_sel[0]) |=> $stable(pll_cfg.feedback_integer_value))
      else $error("integer changed without upper byte write");

   a_sdm_hold: assert property // RULE_06
      (!(wr_hit && (offset == apfc_pkg::OFS_SDM)) |=> $stable(sdm_q))
      else $error("modulator control changed without a write");

   a_cfg_hold: assert property // RULE_10
      (!(wr_hit && (offset == apfc_pkg::OFS_CFG)) |=> $stable(cfg_q))
      else $error("reference config changed without a write");

   a_lpf_hold: assert property // RULE_13
      (!(wr_hit && (offset == apfc_pkg::OFS_LPF)) |=> $stable(lpf_q))
      else $error("loop filter config changed without a write");

   // A miss must leave every PLL control untouched, whatever the page and address size
   a_miss_ignored: assert property // RULE_16
      (acc.valid && acc.write && !hit |=> $stable(pll_cfg))
      else $error("write outside the bank changed the PLL controls");

   a_miss_reads_zero: assert property // RULE_16
      (acc.valid && !acc.write && !hit |=> rd_valid && rd_data == 8'h00)
      else $error("read outside the bank returned data");

   a_rd_answer: assert property // RULE_16
      (acc.valid && !acc.write |=> rd_valid)
      else $error("read not answered one cycle later");

   a_rd_quiet: assert property // RULE_14
      (!(acc.valid && !acc.write) |=> !rd_valid && rd_data == 8'h00)
      else $error("read answer without a read request");

   a_sdm_read: assert property // RULE_08
      (acc.valid && !acc.write && hit && (offset == apfc_pkg::OFS_SDM) |=> rd_data == $past(sdm_q))
      else $error("modulator control read back wrong");

   a_lpf_read: assert property // RULE_11
      (acc.valid && !acc.write && hit && (offset == apfc_pkg::OFS_LPF) |=> rd_data == $past(lpf_q))
      else $error("loop filter config read back wrong");

   c_frac_commit: cover property (frac_wr && (frac_sel == 2'd3));
   c_int_commit:  cover property (int_wr && int_sel[0]);
   c_long_addr:   cover property (wr_hit && addr_two_byte);
   c_lpf_read:    cover property (rd_valid && (rd_off_q == apfc_pkg::OFS_LPF));
   c_miss_write:  cover property (acc.valid && acc.write && !hit);

endmodule : apfc_feedback_regs
`default_nettype wire

/* File: tb/apfc_feedback_regs_test.sv */
// Self-checking bench for the PLL feedback configuration bank
`timescale 1ns/100ps
`default_nettype none
module apfc_feedback_regs_test;
   logic                    mclk;
   logic                    rstn;
   apfc_pkg::apfc_acc_t     acc;
   logic                    addr_two_byte;
   logic [31:0]             page_addr;
   logic [7:0]              rd_data;
   logic                    rd_valid;
   apfc_pkg::apfc_pll_cfg_t pll_cfg;
   int                      fails;
   int                      checked;
   logic [7:0]              dflt [10];

   apfc_feedback_regs DUT
   (
      .mclk          (mclk),
      .rstn          (rstn),
      .acc           (acc),
      .addr_two_byte (addr_two_byte),
      .page_addr     (page_addr),
      .rd_data       (rd_data),
      .rd_valid      (rd_valid),
      .pll_cfg       (pll_cfg)
   );

   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH t=%0t %s: seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : chk

   // Request stays up past its sampling edge; the next call or idle replaces it
   task automatic acc_put(input logic w, input logic [15:0] a, input logic [7:0] d);
      acc = '{valid: 1'b1, write: w, addr: a, wdata: d};
      @(posedge mclk);
      #1;
   endtask : acc_put

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      acc_put(1'b1, a, d);
   endtask : wr

   // Answer is due exactly one cycle after the request edge
   task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string msg);
      acc_put(1'b0, a, 8'h00);
      chk({rd_valid, rd_data}, {1'b1, exp}, msg);
   endtask : rd

   task automatic idle;
      acc.valid = 1'b0;
      @(posedge mclk);
      #1;
   endtask : idle

   task automatic do_reset;
      acc.valid = 1'b0;
      rstn = 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      rstn = 1'b1;
   endtask : do_reset

   task automatic check_defaults;
      chk(pll_cfg.feedback_fraction_value, 32'h0, "frac reset");
      chk(pll_cfg.feedback_integer_value, 32'h6C, "int reset");
      chk({pll_cfg.dither_on, pll_cfg.dither_shaping_on, pll_cfg.dither_gain_code}, 32'h0, "dither reset");
      chk(pll_cfg.modulator_order_code, 32'h3, "order reset");
      chk({pll_cfg.ref_from_external_clock, pll_cfg.doubler_on}, 32'h1, "cfg reset");
      chk({pll_cfg.vco_filter_bypass, pll_cfg.pole_capacitor_code, pll_cfg.filter_resistor_code},
          32'h76, "lpf reset");
      for (int i = 0; i < 10; i++)
         rd(16'(i), dflt[i], "reset readback");
      idle;
   endtask : check_defaults

   initial
   begin
      repeat (3000) @(posedge mclk);
      fails++;
      stop_test;
   end

   initial
   begin
      rstn          = 1'b0;
      acc           = '0;
      addr_two_byte = 1'b0;
      page_addr     = 32'h0000_0100;
      fails         = 0;
      checked       = 0;
      dflt          = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h6C, 8'h00, 8'h03, 8'h01, 8'h76, 8'h00};
      #1;
      do_reset;
      check_defaults;
      // Lower bytes must sit in staging until the top byte lands
      wr(16'h00, 8'hA5);
      wr(16'h01, 8'h5A);
      wr(16'h02, 8'hC3);
      idle;
      chk(pll_cfg.feedback_fraction_value, 32'h0, "frac staged");
      rd(16'h02, 8'hC3, "frac staged read");
      wr(16'h03, 8'hFF);
      idle;
      chk(pll_cfg.feedback_fraction_value, 32'h7C35AA5, "frac commit");
      rd(16'h03, 8'h07, "frac top reserved");
      wr(16'h00, 8'h11);
      wr(16'h03, 8'h00);
      idle;
      chk(pll_cfg.feedback_fraction_value, 32'h0C35A11, "frac back to back");
      wr(16'h04, 8'h12);
      idle;
      chk(pll_cfg.feedback_integer_value, 32'h6C, "int staged");
      wr(16'h05, 8'hFE);
      idle;
      chk(pll_cfg.feedback_integer_value, 32'h212, "int commit");
      rd(16'h05, 8'h02, "int top reserved");
      wr(16'h06, 8'hFF);
      rd(16'h06, 8'h3F, "sdm reserved");
      chk({pll_cfg.dither_on, pll_cfg.dither_shaping_on, pll_cfg.dither_gain_code, pll_cfg.modulator_order_code},
          32'h3F, "sdm all ones");
      for (int k = 0; k < 4; k++)
      begin
         wr(16'h06, {4'h2, 2'(k), 2'(3 - k)});
         idle;
         chk({pll_cfg.dither_on, pll_cfg.dither_shaping_on, pll_cfg.dither_gain_code, pll_cfg.modulator_order_code},
             {26'h0, 2'b10, 2'(k), 2'(3 - k)}, "sdm codes");
      end
      wr(16'h07, 8'hFE);
      idle;
      chk({pll_cfg.ref_from_external_clock, pll_cfg.doubler_on}, 32'h2, "cfg write");
      rd(16'h07, 8'h02, "cfg reserved");
      wr(16'h08, 8'h8A);
      idle;
      chk({pll_cfg.vco_filter_bypass, pll_cfg.pole_capacitor_code, pll_cfg.filter_resistor_code},
          32'h8A, "lpf write");
      rd(16'h08, 8'h8A, "lpf read");
      // Misses: unmapped offset, then a foreign page
      wr(16'h09, 8'hFF);
      rd(16'h09, 8'h00, "unmapped read");
      page_addr = 32'h0000_0200;
      rd(16'h08, 8'h00, "page miss read");
      wr(16'h08, 8'h00);
      idle;
      chk(pll_cfg.filter_resistor_code, 32'hA, "page miss write");
      page_addr     = 32'h0000_0000;
      addr_two_byte = 1'b1;
      rd(16'h0108, 8'h8A, "two-byte hit");
      rd(16'h0008, 8'h00, "two-byte miss");
      wr(16'h0107, 8'h01);
      chk({rd_valid, rd_data}, 32'h0, "no answer to write");
      idle;
      chk({pll_cfg.ref_from_external_clock, pll_cfg.doubler_on}, 32'h1, "two-byte write");
      wr(16'h0207, 8'h02);
      idle;
      chk({pll_cfg.ref_from_external_clock, pll_cfg.doubler_on}, 32'h1, "two-byte write miss");
      addr_two_byte = 1'b0;
      page_addr     = 32'h0000_0100;
      do_reset;
      check_defaults;
      stop_test;
   end
endmodule : apfc_feedback_regs_test
`default_nettype wire
